/* hw/sclkg_map.svh */
`ifndef SCLKG_MAP_SVH
`define SCLKG_MAP_SVH
// Register offsets
`define SCLKG_OFF_RUN_GATE 12'h100
`define SCLKG_OFF_SLEEP_GATE 12'h110
`define SCLKG_OFF_DEEP_GATE 12'h120
`define SCLKG_OFF_CLK_CFG 12'h060
`define SCLKG_OFF_INT_STAT 12'h130
`define SCLKG_OFF_INT_EN 12'h134
`define SCLKG_OFF_INT_CLR 12'h138
// Field positions
`define SCLKG_WDOG_BIT 3
`define SCLKG_AUTO_GATE_BIT 27
`define SCLKG_MODE_BIT 0
`define SCLKG_FAULT_BIT 0
// Reset values and write masks
`define SCLKG_GATE_RST 32'h0000_0000
`define SCLKG_CFG_RST 32'h0000_0000
`define SCLKG_INT_RST 32'h0000_0000
`define SCLKG_WDOG_MASK 32'h0000_0008
`define SCLKG_CFG_MASK 32'h0800_0000
`define SCLKG_INT_MASK 32'h0000_0001
`endif

/* hw/sclkg_pkg.sv */
`default_nettype none
package sclkg_pkg;
  typedef enum logic [1:0] {
    SCLKG_RUN,
    SCLKG_SLEEP,
    SCLKG_DEEP
  } sclkg_mode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } sclkg_wb_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] dat;
  } sclkg_wb_rsp_t;
endpackage
`default_nettype wire

/* hw/sclkg_unit_gate.sv */
`timescale 1ns/10ps
`default_nettype none
// Gate for one unit: clock enable and fault on access while gated
module sclkg_unit_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_en_i,
  input wire logic sleep_en_i,
  input wire logic deep_en_i,
  input wire logic auto_gate_i,
  input wire sclkg_pkg::sclkg_mode_t mode_i,
  input wire logic unit_acc_i,
  output logic clk_en_o,
  output logic fault_o
);
  import sclkg_pkg::*;
  logic en_r;
  logic en_nxt;

  always_comb begin
    en_nxt = run_en_i;
    if (auto_gate_i) begin
      case (mode_i)
        SCLKG_SLEEP: en_nxt = sleep_en_i;
        SCLKG_DEEP: en_nxt = deep_en_i;
        default: en_nxt = run_en_i;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end

  assign clk_en_o = en_r;
  assign fault_o = unit_acc_i & ~en_r;
endmodule
`default_nettype wire

/* hw/sclkg_ctrl.sv */
// Function
// - A set gating bit clocks its unit, a clear bit stops its clock.
// - Any access to a unit whose clock is gated off answers with a bus fault.
// - After reset all gating bits are zero so every gated unit is unclocked.
// - Sleep-mode gating is applied only while the auto-gating select bit is set.
// - Bit 3 is a read/write watchdog gate bit resetting to zero.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sclkg_map.svh"
module sclkg_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sclkg_pkg::sclkg_wb_req_t wb_req_i,
  output sclkg_pkg::sclkg_wb_rsp_t wb_rsp_o,
  input wire sclkg_pkg::sclkg_mode_t mode_i,
  input wire logic wdog_acc_i,
  output logic wdog_clk_en_o,
  output logic wdog_fault_o,
  output logic irq_o
);
  import sclkg_pkg::*;

  logic [31:0] run_r;
  logic [31:0] run_nxt;
  logic [31:0] slp_r;
  logic [31:0] slp_nxt;
  logic [31:0] deep_r;
  logic [31:0] deep_nxt;

  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;

  logic [31:0] ist_r;
  logic [31:0] ist_nxt;
  logic [31:0] ien_r;
  logic [31:0] ien_nxt;

  logic ack_r;
  logic ack_nxt;
  logic err_r;
  logic err_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;

  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [31:0] rd_val;
  logic hit;
  logic req;
  logic wr;
  logic wr_run;
  logic wr_slp;
  logic wr_deep;
  logic wr_cfg;
  logic wr_ien;
  logic wr_iclr;

  logic fault;
  logic wdog_run_en;
  logic wdog_slp_en;
  logic wdog_deep_en;
  logic auto_gate;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wb_req_i.sel[i]}};
    end
  end

  assign wdata = wb_req_i.dat & wmask;

  // Not taken again while the last answer still stands
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_r & ~err_r;
  assign wr = req & wb_req_i.we & hit;

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (wb_req_i.adr)
      `SCLKG_OFF_RUN_GATE: rd_val = run_r;
      `SCLKG_OFF_SLEEP_GATE: rd_val = slp_r;
      `SCLKG_OFF_DEEP_GATE: rd_val = deep_r;
      `SCLKG_OFF_CLK_CFG: rd_val = cfg_r;
      `SCLKG_OFF_INT_STAT: rd_val = ist_r;
      `SCLKG_OFF_INT_EN: rd_val = ien_r;
      `SCLKG_OFF_INT_CLR: rd_val = 32'h0000_0000;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_run = 1'b0;
    wr_slp = 1'b0;
    wr_deep = 1'b0;
    wr_cfg = 1'b0;
    wr_ien = 1'b0;
    wr_iclr = 1'b0;
    if (wr) begin
      case (wb_req_i.adr)
        `SCLKG_OFF_RUN_GATE: wr_run = 1'b1;
        `SCLKG_OFF_SLEEP_GATE: wr_slp = 1'b1;
        `SCLKG_OFF_DEEP_GATE: wr_deep = 1'b1;
        `SCLKG_OFF_CLK_CFG: wr_cfg = 1'b1;
        `SCLKG_OFF_INT_EN: wr_ien = 1'b1;
        `SCLKG_OFF_INT_CLR: wr_iclr = 1'b1;
        default: begin
        end
      endcase
    end
  end

  // Only the watchdog bit is kept, the rest read as zero
  always_comb begin
    run_nxt = run_r;
    slp_nxt = slp_r;
    deep_nxt = deep_r;
    if (wr_run) begin
      run_nxt = (run_r & ~wmask) | (wdata & `SCLKG_WDOG_MASK);
    end
    if (wr_slp) begin
      slp_nxt = (slp_r & ~wmask) | (wdata & `SCLKG_WDOG_MASK);
    end
    if (wr_deep) begin
      deep_nxt = (deep_r & ~wmask) | (wdata & `SCLKG_WDOG_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= `SCLKG_GATE_RST;
      slp_r <= `SCLKG_GATE_RST;
      deep_r <= `SCLKG_GATE_RST;
    end else begin
      run_r <= run_nxt;
      slp_r <= slp_nxt;
      deep_r <= deep_nxt;
    end
  end

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = (cfg_r & ~wmask) | (wdata & `SCLKG_CFG_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `SCLKG_CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_comb begin
    ien_nxt = ien_r;
    ist_nxt = ist_r;
    if (wr_ien) begin
      ien_nxt = (ien_r & ~wmask) | (wdata & `SCLKG_INT_MASK);
    end
    if (wr_iclr) begin
      ist_nxt = ist_r & ~wdata;
    end
    // Set beats a same-cycle clear
    if (fault) begin
      ist_nxt[`SCLKG_FAULT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_r <= `SCLKG_INT_RST;
      ien_r <= `SCLKG_INT_RST;
    end else begin
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
    end
  end

  always_comb begin
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    rdat_nxt = rdat_r;
    if (req) begin
      ack_nxt = hit;
      err_nxt = ~hit;
      rdat_nxt = wb_req_i.we ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wdog_run_en = run_r[`SCLKG_WDOG_BIT];
  assign wdog_slp_en = slp_r[`SCLKG_WDOG_BIT];
  assign wdog_deep_en = deep_r[`SCLKG_WDOG_BIT];
  assign auto_gate = cfg_r[`SCLKG_AUTO_GATE_BIT];

  sclkg_unit_gate u_wdog_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_en_i(wdog_run_en),
    .sleep_en_i(wdog_slp_en),
    .deep_en_i(wdog_deep_en),
    .auto_gate_i(auto_gate),
    .mode_i(mode_i),
    .unit_acc_i(wdog_acc_i),
    .clk_en_o(wdog_clk_en_o),
    .fault_o(fault)
  );

  assign wdog_fault_o = fault;
  assign irq_o = |(ist_r & ien_r);
  assign wb_rsp_o = '{ack: ack_r, err: err_r, dat: rdat_r};
endmodule
`default_nettype wire

/* verification/sclkg_ctrl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module sclkg_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sclkg_pkg::sclkg_wb_req_t wb_req_i,
  input wire sclkg_pkg::sclkg_wb_rsp_t wb_rsp_o,
  input wire sclkg_pkg::sclkg_mode_t mode_i,
  input wire logic wdog_acc_i,
  input wire logic wdog_clk_en_o,
  input wire logic wdog_fault_o,
  input wire logic irq_o
);
  import sclkg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_fault_gated: assert property (wdog_fault_o == (wdog_acc_i && !wdog_clk_en_o))
    else $error("fault");
  a_reset_clear: assert property ($fell(rst_i) |-> !wdog_clk_en_o)
    else $error("reset");
  a_enable_cause: assert property ($changed(wdog_clk_en_o) |->
    $past(wb_rsp_o.ack && wb_req_i.we) || $past(mode_i) != $past(mode_i, 2)) else $error("enable");
  a_reserved_zero: assert property (wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == 12'h110 |->
    (wb_rsp_o.dat & 32'hffff_fff7) == 32'h0) else $error("reserved");
  a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held");
  a_err_single: assert property (wb_rsp_o.err |=> !wb_rsp_o.err)
    else $error("err held");
  a_irq_cause: assert property ($rose(irq_o) |->
    $past(wdog_fault_o || (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we))) else $error("irq cause");
endmodule
bind sclkg_ctrl sclkg_ctrl_sva u_sva (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .mode_i, .wdog_acc_i,
  .wdog_clk_en_o, .wdog_fault_o, .irq_o);
`default_nettype wire

/* verification/sclkg_ctrl_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module sclkg_ctrl_bench;
  import sclkg_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic acc = 0;
  logic en, flt, irq, er;
  logic [31:0] rd;
  sclkg_wb_req_t rq = '0;
  sclkg_wb_rsp_t rs;
  sclkg_mode_t md = SCLKG_RUN;
  int mismatches = 0;
  int checks = 0;
  sclkg_ctrl DUT (.clk_i, .rst_i, .wb_req_i(rq), .wb_rsp_o(rs), .mode_i(md), .wdog_acc_i(acc),
    .wdog_clk_en_o(en), .wdog_fault_o(flt), .irq_o(irq));
  initial forever #2 clk_i = ~clk_i;
  initial begin
    #4000;
    mismatches++;
    complete_run;
  end
  task automatic complete_run;
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] a, e);
    checks++;
    if (a !== e) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    rq <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do cy(1); while (!(rs.ack | rs.err));
    rd = rs.dat;
    er = rs.err;
    rq <= '0;
    cy(1);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    wb(0, a, 0);
    ck(rd, e);
  endtask
  task automatic t_regs;
    wb(1, 12'h110, '1);
    rc(12'h110, 32'h8);
    rst_i <= 1;
    cy(3);
    rst_i <= 0;
    cy(1);
    rc(12'h110, 0);
    wb(0, 12'hffc, 0);
    ck(er, 1);
  endtask
  task automatic t_modes;
    wb(1, 12'h100, 32'h8);
    md <= SCLKG_SLEEP;
    cy(2);
    ck(en, 1);
    wb(1, 12'h060, 32'h0800_0000);
    ck(en, 0);
    wb(1, 12'h110, 32'h8);
    ck(en, 1);
    md <= SCLKG_DEEP;
    cy(2);
    ck(en, 0);
    md <= SCLKG_RUN;
    cy(2);
    ck(en, 1);
  endtask
  task automatic t_fault;
    wb(1, 12'h134, 32'h1);
    acc <= 1;
    cy(1);
    ck(flt, 0);
    wb(1, 12'h100, 0);
    ck(flt, 1);
    acc <= 0;
    cy(1);
    ck(irq, 1);
    wb(1, 12'h138, 32'h1);
    rc(12'h130, 0);
    wb(1, 12'h134, 0);
    acc <= 1;
    cy(1);
    acc <= 0;
    cy(1);
    ck(irq, 0);
    rc(12'h130, 32'h1);
  endtask
  initial begin
    cy(3);
    rst_i <= 0;
    cy(1);
    t_regs;
    t_modes;
    t_fault;
    complete_run;
  end
endmodule
`default_nettype wire
